// ### core/power_sequencer.sv
/*
   Server power sequencer: sits between the front panel button, the chipset soft-off sleep
   signal and the chassis supply. Drives the supply on-request, emulates button presses,
   times power-up, power-down and the dropout retry, and gates power-on until ready.
   Assumes firmware-side inputs are synchronous to clk_in and that pins are asynchronous.
   The non-volatile store lives outside; this block reports what to store and reads back
   the stored state while it boots.
*/

module power_sequencer #(
   parameter int unsigned DEBOUNCE_CYC  = pwr_seq_pkg::DEBOUNCE_CYC,
   parameter int unsigned PRESS_CYC     = pwr_seq_pkg::PRESS_CYC,
   parameter int unsigned GOOD_WAIT_CYC = pwr_seq_pkg::GOOD_WAIT_CYC,
   parameter int unsigned RETRY_CYC     = pwr_seq_pkg::RETRY_CYC
) (
   input  wire logic                  clk_in,
   input  wire logic                  srst_in,
   input  wire logic                  ce_in,
   input  wire logic                  button_in,
   input  wire logic                  sleep_in,
   input  wire logic                  supply_good_in,
   input  wire logic                  force_update_in,
   input  wire logic                  fw_running_in,
   input  wire logic                  block_button_in,
   input  wire logic                  init_done_in,
   input  wire logic                  transit_done_in,
   input  wire logic                  hold_off_in,
   input  wire pwr_seq_pkg::command_t command_in,
   input  wire logic [1:0]            restore_policy_in,
   input  wire logic                  nv_state_in,
   output logic                       supply_on_request_out,
   output logic                       chipset_button_out,
   output logic                       pass_enable_out,
   output logic                       sio_enable_out,
   output logic                       power_unit_fail_out,
   output logic                       nv_state_out,
   output pwr_seq_pkg::event_t        events_out
);

   // Whole sequencer state in one register
   typedef struct packed {
      pwr_seq_pkg::seq_state_t        state;
      logic [pwr_seq_pkg::TIMER_W-1:0] timer;
      logic                           on_req;
      logic                           press;
      logic                           button_out;
      logic                           pass_en;
      logic                           sio_en;
      logic                           fail;
      logic                           nv_state;
      pwr_seq_pkg::event_t            ev;
   } seq_regs_t;

   seq_regs_t cur;
   seq_regs_t next_cur;

   logic [pwr_seq_pkg::N_CH-1:0] pins_raw;
   logic [pwr_seq_pkg::N_CH-1:0] pins_db;
   logic                         button_db;
   logic                         sleep_db;
   logic                         good_db;
   logic                         force_db;
   logic                         allowed;
   logic                         timer_done;
   logic                         policy_on;
   pwr_seq_pkg::restore_policy_t policy;

   // Timer reload values, one cycle shorter because the reload cycle counts
   localparam logic [pwr_seq_pkg::TIMER_W-1:0] PRESS_LOAD = pwr_seq_pkg::TIMER_W'(PRESS_CYC - 1);
   localparam logic [pwr_seq_pkg::TIMER_W-1:0] GOOD_LOAD  = pwr_seq_pkg::TIMER_W'(GOOD_WAIT_CYC - 1);
   localparam logic [pwr_seq_pkg::TIMER_W-1:0] RETRY_LOAD = pwr_seq_pkg::TIMER_W'(RETRY_CYC - 1);

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   // Pins pass through sync and filter; supply good and jumper get the sync stage and a one-cycle filter
   // so a dropout is seen within a few cycles, far inside the 2 ms budget
   assign pins_raw = {force_update_in, supply_good_in, sleep_in, button_in};

   for (genvar i = 0; i < pwr_seq_pkg::N_CH; i++) begin : g_deb
      input_debouncer #(
         .CYCLES ((i == pwr_seq_pkg::CH_BUTTON || i == pwr_seq_pkg::CH_SLEEP) ? DEBOUNCE_CYC : 1)
      ) u_deb (
         .clk_in    (clk_in),
         .srst_in   (srst_in),
         .ce_in     (ce_in),
         .raw_in    (pins_raw[i]),
         .level_out (pins_db[i])
      );
   end

   assign button_db = pins_db[pwr_seq_pkg::CH_BUTTON];
   assign sleep_db  = pins_db[pwr_seq_pkg::CH_SLEEP];
   assign good_db   = pins_db[pwr_seq_pkg::CH_GOOD];
   assign force_db  = pins_db[pwr_seq_pkg::CH_FORCE];

   // Power-on gate: both button paths open, or the update jumper overrides
   assign allowed    = force_db | (cur.pass_en & cur.sio_en);
   assign timer_done = (cur.timer == '0);

   // Unused fourth policy code falls back to stay off
   assign policy    = pwr_seq_pkg::restore_policy_t'(restore_policy_in);
   assign policy_on = (policy == pwr_seq_pkg::POLICY_ON) || (policy == pwr_seq_pkg::POLICY_RESTORE);

   // Next-state logic for the whole sequencer
   always_comb begin
      next_cur = cur;
      next_cur.ev = '0;
      // Firmware may block the pass-through only while it runs
      next_cur.pass_en = !fw_running_in || !block_button_in;
      if (!timer_done) begin
         next_cur.timer = cur.timer - 1'b1;
      end

      // On-request follows the chipset sleep signal, rising only when power-on is
      // allowed and transitional work is done
      if (!cur.on_req && sleep_db && allowed && transit_done_in &&
          (cur.state == pwr_seq_pkg::ST_OFF || cur.state == pwr_seq_pkg::ST_PRESS_ON)) begin
         next_cur.on_req = 1'b1;
      end
      // Falling is held back while firmware still finishes transitional work
      if (cur.on_req && !sleep_db && !hold_off_in) begin
         next_cur.on_req = 1'b0;
      end

      unique case (cur.state)
         pwr_seq_pkg::ST_BOOT: begin
            // Super I/O button path stays off until the init phase is done
            if (init_done_in) begin
               next_cur.sio_en = 1'b1;
               if (policy == pwr_seq_pkg::POLICY_ON ||
                   (policy == pwr_seq_pkg::POLICY_RESTORE && nv_state_in)) begin
                  next_cur.state = pwr_seq_pkg::ST_PRESS_ON;
                  next_cur.timer = PRESS_LOAD;
               end else begin
                  next_cur.state = pwr_seq_pkg::ST_OFF;
               end
            end else if (!fw_running_in && force_db) begin
               next_cur.state = pwr_seq_pkg::ST_PRESS_ON;
               next_cur.timer = PRESS_LOAD;
            end
         end
         pwr_seq_pkg::ST_OFF: begin
            if (next_cur.on_req) begin
               // Chipset-initiated power-on, e.g. from its own wake logic
               next_cur.state = pwr_seq_pkg::ST_WAIT_GOOD;
               next_cur.timer = GOOD_LOAD;
            end else if (command_in.power_on) begin
               next_cur.state = pwr_seq_pkg::ST_PRESS_ON;
               next_cur.timer = PRESS_LOAD;
            end
         end
         pwr_seq_pkg::ST_PRESS_ON: begin
            next_cur.press = 1'b1;
            if (good_db && cur.on_req) begin
               next_cur.press = 1'b0;
               next_cur.ev.sensor_init = 1'b1;
               next_cur.fail = 1'b0;
               next_cur.nv_state = 1'b1;
               next_cur.ev.nv_write = 1'b1;
               next_cur.state = pwr_seq_pkg::ST_ON;
            end else if (timer_done) begin
               next_cur.press = 1'b0;
               next_cur.on_req = 1'b0;
               next_cur.ev.fault = 1'b1;
               next_cur.state = pwr_seq_pkg::ST_OFF;
            end
         end
         pwr_seq_pkg::ST_WAIT_GOOD: begin
            if (good_db) begin
               next_cur.ev.sensor_init = 1'b1;
               next_cur.fail = 1'b0;
               next_cur.nv_state = 1'b1;
               next_cur.ev.nv_write = 1'b1;
               next_cur.state = pwr_seq_pkg::ST_ON;
            end else if (timer_done) begin
               next_cur.on_req = 1'b0;
               next_cur.ev.fault = 1'b1;
               next_cur.state = pwr_seq_pkg::ST_OFF;
            end
         end
         pwr_seq_pkg::ST_ON: begin
            if (cur.on_req && !good_db) begin
               // Dropout: drop the supply at once, then wait before any retry
               next_cur.on_req = 1'b0;
               next_cur.fail = 1'b1;
               next_cur.ev.dropout_irq = 1'b1;
               next_cur.ev.log_event = 1'b1;
               next_cur.timer = RETRY_LOAD;
               next_cur.state = pwr_seq_pkg::ST_DROP_WAIT;
            end else if (!cur.on_req && !good_db) begin
               // Chipset-initiated power-off has completed
               next_cur.nv_state = 1'b0;
               next_cur.ev.nv_write = 1'b1;
               next_cur.state = pwr_seq_pkg::ST_OFF;
            end else if (command_in.power_off) begin
               next_cur.ev.stop_scan = 1'b1;
               next_cur.timer = PRESS_LOAD;
               next_cur.state = pwr_seq_pkg::ST_PRESS_OFF;
            end
         end
         pwr_seq_pkg::ST_PRESS_OFF: begin
            next_cur.press = 1'b1;
            if (!good_db) begin
               next_cur.press = 1'b0;
               next_cur.nv_state = 1'b0;
               next_cur.ev.nv_write = 1'b1;
               next_cur.state = pwr_seq_pkg::ST_OFF;
            end else if (timer_done) begin
               next_cur.press = 1'b0;
               next_cur.ev.fault = 1'b1;
               next_cur.state = pwr_seq_pkg::ST_ON;
            end
         end
         pwr_seq_pkg::ST_DROP_WAIT: begin
            // Supply stays off for the whole wait whatever the chipset does
            next_cur.on_req = 1'b0;
            if (timer_done) begin
               if (policy_on) begin
                  next_cur.state = pwr_seq_pkg::ST_PRESS_ON;
                  next_cur.timer = PRESS_LOAD;
               end else begin
                  next_cur.state = pwr_seq_pkg::ST_OFF;
               end
            end
         end
         default: begin
            // Unused code: fail safe with the supply released
            next_cur.state = pwr_seq_pkg::ST_OFF;
            next_cur.on_req = 1'b0;
            next_cur.press = 1'b0;
         end
      endcase

      // Chipset button: emulated press, or the front panel through an open pass-through;
      // the chipset acts on the rising edge only, so release timing is not critical
      next_cur.button_out = next_cur.press |
                            (button_db & next_cur.pass_en & (cur.sio_en | !fw_running_in));
   end

   // State register; reset puts all fields to zero, which is ST_BOOT with everything off
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         cur <= '0;
      end else if (ce_in) begin
         cur <= next_cur;
      end
   end

   // Outputs straight from the state register
   assign supply_on_request_out = cur.on_req;
   assign chipset_button_out    = cur.button_out;
   assign pass_enable_out       = cur.pass_en;
   assign sio_enable_out        = cur.sio_en;
   assign power_unit_fail_out   = cur.fail;
   assign nv_state_out          = cur.nv_state;
   assign events_out            = cur.ev;

   // A dropout drops the supply, flags failure and raises the event in one step
   dropout_response_a: assert property (
      (ce_in && cur.state == pwr_seq_pkg::ST_ON && cur.on_req && !good_db)
      |=> (!cur.on_req && cur.fail && cur.ev.dropout_irq && cur.ev.log_event &&
           cur.state == pwr_seq_pkg::ST_DROP_WAIT)
   ) else $error("Dropout not handled in the next cycle");

   // Power-up press ends in a fault when the timer runs out
   press_on_timeout_a: assert property (
      (ce_in && cur.state == pwr_seq_pkg::ST_PRESS_ON && timer_done && !(good_db && cur.on_req))
      |=> (cur.ev.fault && !cur.press && cur.state == pwr_seq_pkg::ST_OFF)
   ) else $error("Power-up press timeout gave no fault");

   // Power-down press ends in a fault when supply good stays high
   press_off_timeout_a: assert property (
      (ce_in && cur.state == pwr_seq_pkg::ST_PRESS_OFF && timer_done && good_db)
      |=> (cur.ev.fault && !cur.press && cur.state == pwr_seq_pkg::ST_ON)
   ) else $error("Power-down press timeout gave no fault");

   // Sensor initialisation only on completion of a power-up
   sensor_init_entry_a: assert property (
      cur.ev.sensor_init |-> (cur.state == pwr_seq_pkg::ST_ON &&
                              ($past(cur.state) == pwr_seq_pkg::ST_PRESS_ON ||
                               $past(cur.state) == pwr_seq_pkg::ST_WAIT_GOOD))
   ) else $error("Sensor init outside power-up completion");

   // Scan stop accompanies entry to the power-down press
   stop_scan_first_a: assert property (
      (cur.state == pwr_seq_pkg::ST_PRESS_OFF && $past(cur.state) != pwr_seq_pkg::ST_PRESS_OFF)
      |-> cur.ev.stop_scan
   ) else $error("Power-down started without stopping scans");

   // On-request rises only through an open gate
   power_gate_a: assert property (
      $rose(cur.on_req) |-> $past(allowed) && $past(transit_done_in)
   ) else $error("On-request raised while power-on was not allowed");

   // Super I/O path remains off while booting
   sio_boot_off_a: assert property (
      cur.state == pwr_seq_pkg::ST_BOOT |-> !cur.sio_en
   ) else $error("Super I/O path enabled before init phase");

   // Hold keeps on-request up while powered and supply good
   hold_off_keep_a: assert property (
      (ce_in && cur.state == pwr_seq_pkg::ST_ON && cur.on_req && good_db && hold_off_in)
      |=> cur.on_req
   ) else $error("On-request dropped during hold");

   // Retry only by policy once the wait ends, with the supply off in the last wait cycle
   retry_policy_a: assert property (
      (cur.state == pwr_seq_pkg::ST_PRESS_ON && $past(cur.state) == pwr_seq_pkg::ST_DROP_WAIT)
      |-> ($past(policy_on) && $past(timer_done) && !$past(cur.on_req))
   ) else $error("Retry after dropout without policy or early");

   // Stopped firmware leaves the pass-through open
   fw_down_pass_a: assert property (
      (ce_in && !fw_running_in) |=> cur.pass_en
   ) else $error("Pass-through blocked while firmware stopped");

endmodule // power_sequencer

// ### core/pwr_seq_pkg.sv
/*
   Shared constants and types for the server power sequencer: clock rate, interval lengths
   and the cycle counts derived from them, debounce channel layout, state and policy codes,
   and the packed carriers used between the sequencer and its user side.
   Assumes a single controller clock and that every user of these names qualifies them.
*/
package pwr_seq_pkg;

   // Controller clock; every interval below is derived from it
   localparam int unsigned CLK_HZ     = 25_000_000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

   // Intervals in their own unit, milliseconds; the sequencer takes the cycle counts below
   localparam int unsigned DEBOUNCE_MS  = 8;
   localparam int unsigned PRESS_MS     = 8000;
   localparam int unsigned GOOD_WAIT_MS = 1500;
   localparam int unsigned RETRY_MS     = 10000;

   // Cycle counts; all fit below 2**31 at this rate
   localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_MS * CYC_PER_MS;
   localparam int unsigned PRESS_CYC     = PRESS_MS * CYC_PER_MS;
   localparam int unsigned GOOD_WAIT_CYC = GOOD_WAIT_MS * CYC_PER_MS;
   localparam int unsigned RETRY_CYC     = RETRY_MS * CYC_PER_MS;

   // Counter widths: the timer holds the 10 s retry, the debouncer holds 8 ms
   localparam int TIMER_W = 28;
   localparam int DB_W    = 18;

   // Input channel positions in the debounced pin vector
   localparam int N_CH      = 4;
   localparam int CH_BUTTON = 0;
   localparam int CH_SLEEP  = 1;
   localparam int CH_GOOD   = 2;
   localparam int CH_FORCE  = 3;

   // Restore policy after AC loss; the fourth code is treated as stay off
   typedef enum logic [1:0] {POLICY_OFF, POLICY_ON, POLICY_RESTORE} restore_policy_t;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_BOOT, ST_OFF, ST_PRESS_ON, ST_WAIT_GOOD, ST_ON, ST_PRESS_OFF, ST_DROP_WAIT
   } seq_state_t;

   // Power change requests from firmware, command processor, watchdog or event filter
   typedef struct packed {
      logic power_on;
      logic power_off;
   } command_t;

   // One-cycle event pulses toward firmware
   typedef struct packed {
      logic dropout_irq;
      logic log_event;
      logic fault;
      logic sensor_init;
      logic stop_scan;
      logic nv_write;
   } event_t;

   // Debouncer state
   typedef struct packed {
      logic [1:0]      sync;
      logic            stable;
      logic [DB_W-1:0] count;
   } debounce_t;

endpackage

// ### core/input_debouncer.sv
/*
   Two-flop synchroniser followed by a stability filter for one pin.
   Assumes the pin is asynchronous to clk_in; the output changes only after the synchronised
   level has differed from it for CYCLES consecutive enabled cycles.
*/
module input_debouncer #(
   parameter int unsigned CYCLES = 1
) (
   input  wire logic clk_in,
   input  wire logic srst_in,
   input  wire logic ce_in,
   input  wire logic raw_in,
   output logic      level_out
);

   pwr_seq_pkg::debounce_t cur;
   pwr_seq_pkg::debounce_t next_cur;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   // Sync stage 0 feeds only stage 1; the counter restarts on every bounce
   always_comb begin
      next_cur = cur;
      next_cur.sync = {cur.sync[0], raw_in};
      if (cur.sync[1] == cur.stable) begin
         next_cur.count = '0;
      end else if (cur.count >= pwr_seq_pkg::DB_W'(CYCLES - 1)) begin
         next_cur.stable = cur.sync[1];
         next_cur.count  = '0;
      end else begin
         next_cur.count = cur.count + 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         cur <= '0;
      end else if (ce_in) begin
         cur <= next_cur;
      end
   end

   assign level_out = cur.stable;

   stable_after_hold_a: assert property (
      (!$past(srst_in) && $changed(cur.stable)) |-> $past(cur.count) == pwr_seq_pkg::DB_W'(CYCLES - 1)
   ) else $error("Debounced level changed before the hold time ran out");

endmodule // input_debouncer

// ### tb/supply_chipset_model.sv
/*
   Behavioural far side of the sequencer: chassis supply and chipset power button logic.
   Assumes the sequencer clock; supply delay is counted in its cycles, drive is 1 ns after the edge.
*/
module supply_chipset_model (
   input  wire logic       clk_in,
   input  wire logic       on_request_in,
   input  wire logic       button_in,
   input  wire logic       mute_in,
   input  wire logic       drop_in,
   input  wire logic [3:0] delay_in,
   output logic            good_out,
   output logic            sleep_out
);
   timeunit 1ns;
   timeprecision 1ns;
   int unsigned wait_cyc    = 0;
   logic        last_button = 1'b0;
   initial begin
      good_out = 1'b0;
      sleep_out = 1'b0;
   end
   // Chipset acts on the press edge only; a lost supply takes the chipset to soft off
   always @(posedge clk_in) begin
      if (drop_in) sleep_out <= #1 1'b0;
      else if (button_in && !last_button) sleep_out <= #1 !sleep_out;
      last_button <= button_in;
   end
   // Good follows the request after a delay and falls while it stands only on drop; mute models a dead supply
   always @(posedge clk_in) begin
      if (!on_request_in || drop_in) begin
         good_out <= #1 1'b0;
         wait_cyc <= 0;
      end else if (!mute_in && wait_cyc >= delay_in) good_out <= #1 1'b1;
      else wait_cyc <= wait_cyc + 1;
   end
endmodule // supply_chipset_model

// ### tb/tb_top.sv
/*
   Self-checking bench for the power sequencer against a behavioural supply and chipset.
   Assumes shortened interval parameters; the phase step counts are derived from them, the settle steps and wait limits are fixed figures.
*/
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DB = 4, PR = 40, GW = 20, RT = 30;
   logic                  clk_in = 1'b0, srst_in = 1'b1, fw_running_in = 1'b0, block_button_in = 1'b0;
   logic                  init_done_in = 1'b0, button_in = 1'b0, mute = 1'b0, drop = 1'b0, btn_seen = 1'b0;
   logic                  ce_in = 1'b1, transit_done_in = 1'b1, hold_off_in = 1'b0;
   logic                  force_update_in = 1'b0, nv_state_in = 1'b0;
   logic [1:0]            restore_policy_in = 2'h0;
   logic [3:0]            dly = 4'h2;
   pwr_seq_pkg::command_t command_in = '0;
   pwr_seq_pkg::event_t   events_out, ev = '0;
   logic                  supply_on_request_out, chipset_button_out, pass_enable_out, sio_enable_out;
   logic                  power_unit_fail_out, nv_state_out, supply_good_in, sleep_in;
   int                    n_fail = 0, n_tests = 0, seed = 32'he723;
   wire logic [2:0]       obs = {nv_state_out, supply_on_request_out, power_unit_fail_out};

   always #20 clk_in = ~clk_in;
   // Sticky copies, so one-cycle pulses are not lost between checks
   always @(posedge clk_in) begin
      ev <= ev | events_out;
      btn_seen <= btn_seen | chipset_button_out;
   end

   power_sequencer #(.DEBOUNCE_CYC(DB), .PRESS_CYC(PR), .GOOD_WAIT_CYC(GW), .RETRY_CYC(RT)) power_sequencer_i (
      .clk_in, .srst_in, .ce_in, .button_in, .sleep_in, .supply_good_in, .force_update_in,
      .fw_running_in, .block_button_in, .init_done_in, .transit_done_in, .hold_off_in,
      .command_in, .restore_policy_in, .nv_state_in, .supply_on_request_out, .chipset_button_out,
      .pass_enable_out, .sio_enable_out, .power_unit_fail_out, .nv_state_out, .events_out);
   supply_chipset_model supply_chipset_model_i (.clk_in, .on_request_in(supply_on_request_out),
      .button_in(chipset_button_out), .mute_in(mute), .drop_in(drop), .delay_in(dly),
      .good_out(supply_good_in), .sleep_out(sleep_in));

   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Bounded wait on one observed output; running out is a mismatch
   task automatic wait_obs(input int idx, input logic val, input int lim);
      int k;
      for (k = 0; k < lim && obs[idx] !== val; k++) step(1);
      check(32'(k < lim), 32'h1);
   endtask
   task automatic pulse_cmd(input logic on);
      dly = 4'($unsigned($random(seed)) % 8);
      ev = '0;
      command_in = on ? 2'h2 : 2'h1;
      step(1);
      command_in = '0;
   endtask
   // Standby restart in mid-run; held as long as the first reset
   task automatic pulse_reset();
      srst_in = 1'b1;
      step(16);
      srst_in = 1'b0;
      step(2);
   endtask
   // Whether power returns by itself when standby power comes back
   function automatic logic boot_on(input logic [1:0] pol, input logic nv);
      return pol == 2'h1 || (pol == 2'h2 && nv);
   endfunction
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Watchdog well beyond the few hundred cycles the sequence needs
   initial begin
      #(40 * 4000);
      n_fail++;
      wrap_up();
   end

   initial begin
      step(16);
      srst_in = 1'b0;
      step(2);
      check(32'(pass_enable_out), 32'h1);
      check(32'({sio_enable_out, supply_on_request_out}), 32'h0);
      fw_running_in = 1'b1;
      block_button_in = 1'b1;
      step(2);
      check(32'(pass_enable_out), 32'h0);
      block_button_in = 1'b0;
      init_done_in = 1'b1;
      step(2);
      check(32'(sio_enable_out), 32'h1);
      // Random bounces shorter than the filter must never reach the chipset
      btn_seen = 1'b0;
      repeat (8) begin
         button_in = 1'b1;
         step(1 + ($unsigned($random(seed)) % (DB - 1)));
         button_in = 1'b0;
         step(DB + 2);
      end
      check(32'(btn_seen), 32'h0);
      // A held press passes; the chipset then raises its sleep signal and the supply comes up
      button_in = 1'b1;
      step(DB + 5);
      button_in = 1'b0;
      check(32'(btn_seen), 32'h1);
      wait_obs(2, 1'b1, 80);
      check(32'(supply_on_request_out), 32'h1);
      // Dropout with an always-on policy: power down, flag, wait, retry
      restore_policy_in = 2'h1;
      dly = 4'($unsigned($random(seed)) % 8);
      ev = '0;
      drop = 1'b1;
      wait_obs(1, 1'b0, 8);
      check(32'(power_unit_fail_out), 32'h1);
      step(2);
      check(32'({ev.dropout_irq, ev.log_event}), 32'h3);
      drop = 1'b0;
      step(RT - 10);
      check(32'(supply_on_request_out), 32'h0);
      wait_obs(0, 1'b0, 90);
      check(32'(events_out.sensor_init), 32'h1);
      // Commanded power-down stops scanning first and completes without a fault
      pulse_cmd(1'b0);
      step(3);
      check(32'(ev.stop_scan), 32'h1);
      wait_obs(2, 1'b0, 60);
      check(32'(ev.fault), 32'h0);
      // Dead supply: the power-up press times out, then the chipset wait times out as well
      mute = 1'b1;
      pulse_cmd(1'b1);
      step(PR - 2);
      check(32'(ev.fault), 32'h0);
      step(6);
      check(32'(ev.fault), 32'h1);
      ev = '0;
      step(GW + 6);
      check(32'(ev.fault), 32'h1);
      mute = 1'b0;
      wait_obs(2, 1'b1, 60);
      // Chipset goes to soft off while firmware holds the supply up; release lets it finish
      hold_off_in = 1'b1;
      button_in = 1'b1;
      step(DB + 5);
      button_in = 1'b0;
      step(DB + 8);
      check(32'(supply_on_request_out), 32'h1);
      hold_off_in = 1'b0;
      wait_obs(2, 1'b0, 20);
      check(32'({supply_on_request_out, events_out.nv_write}), 32'h1);
      // Chipset wakes with transitional work pending: no supply until done; a low enable freezes all
      transit_done_in = 1'b0;
      button_in = 1'b1;
      step(DB + 5);
      button_in = 1'b0;
      step(DB + 8);
      check(32'(supply_on_request_out), 32'h0);
      ce_in = 1'b0;
      transit_done_in = 1'b1;
      step(4);
      check(32'(supply_on_request_out), 32'h0);
      ce_in = 1'b1;
      step(2);
      check(32'(supply_on_request_out), 32'h1);
      wait_obs(2, 1'b1, 30);
      // Standby restart with a restore policy and a stored on state brings power back
      pulse_cmd(1'b0);
      wait_obs(2, 1'b0, 60);
      restore_policy_in = 2'h2;
      nv_state_in = 1'b1;
      pulse_reset();
      check(32'({sio_enable_out, obs}), 32'h8);
      wait_obs(2, boot_on(restore_policy_in, nv_state_in), 40);
      // Firmware stopped with the update jumper set: power-on is still permitted from boot
      pulse_cmd(1'b0);
      wait_obs(2, 1'b0, 60);
      fw_running_in = 1'b0;
      init_done_in = 1'b0;
      force_update_in = 1'b1;
      pulse_reset();
      check(32'({pass_enable_out, sio_enable_out, obs}), 32'h10);
      wait_obs(2, 1'b1, 60);
      wrap_up();
   end
endmodule // tb_top
